// ==== hw/refresh_ctl_defs.svh ====
// Constants for the refresh and self-refresh control ends.
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef REFRESH_CTL_DEFS_SVH
`define REFRESH_CTL_DEFS_SVH
`define CLK_NS 40
`define TRP_NS 14
`define TRFC_NS 260
`define TCKE_NS 80
`define TCKSRE_NS 80
`define TCKSRX_NS 80
`define TXS_NS 270
`define TXSDLL_CYC 512
`define TREFI_NS 7800
`define TCCD_CYC 4
`define DEBT_MAX 8
`define CNT_W 16
`define ROW_W 15
`define COL_W 10
`define CEIL_CYC(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`endif

// ==== hw/refresh_ctl_pkg.sv ====
// Types shared by both ends of the refresh control link.
package refresh_ctl_pkg;
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_REF = 3'h1,
    CMD_SRE = 3'h2,
    CMD_RD = 3'h3,
    CMD_WR = 3'h4,
    CMD_OTHER = 3'h5
  } cmd_t;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'h0,
    DEV_REFRESH = 3'h1,
    DEV_SELF = 3'h3,
    DEV_EXIT = 3'h2
  } dev_state_t;
  typedef enum logic [2:0] {
    CTL_READY = 3'h0,
    CTL_REF_WAIT = 3'h1,
    CTL_SELF = 3'h3,
    CTL_EXIT = 3'h2,
    CTL_PREP = 3'h6
  } ctl_state_t;
endpackage : refresh_ctl_pkg

// ==== hw/dram_cmd_if.sv ====
// Command pins between the controller and the memory device.
`timescale 1ns/10ps
`include "refresh_ctl_defs.svh"
interface dram_cmd_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic a12;
  logic [`COL_W-1:0] col;
  logic reset_n;
  logic clk_en;
  modport device (
    input cs_n, ras_n, cas_n, we_n, cke, a12, col, reset_n, clk_en
  );
  modport controller (
    output cs_n, ras_n, cas_n, we_n, cke, a12, col, reset_n, clk_en
  );
endinterface : dram_cmd_if

// ==== hw/cycle_timer.sv ====
// Loadable down-counter that reports when a wait has run out.
`timescale 1ns/10ps
module cycle_timer #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  input wire logic load,
  input wire logic [W-1:0] value,
  // Status.
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } timer_state_t;
  timer_state_t s;
  timer_state_t next_s;

  always_comb begin
    next_s = s;
    if (load) begin
      next_s.cnt = value;
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = (s.cnt == '0) && !load;
endmodule : cycle_timer

// ==== hw/dram_refresh_device.sv ====
// Device end: command decode, refresh, self-refresh and DLL handling.
`timescale 1ns/10ps
`include "refresh_ctl_defs.svh"
module dram_refresh_device #(
  parameter int TREFI_CYC = `CEIL_CYC(`TREFI_NS)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Link.
  dram_cmd_if.device link,
  // Status toward the user side.
  output refresh_ctl_pkg::dev_state_t state,
  output logic [`ROW_W-1:0] refresh_row,
  output logic refresh_pulse,
  output logic dll_on,
  output logic dll_reset,
  output logic burst_length_eight,
  output logic [`COL_W-1:0] column,
  output logic access_pulse,
  output logic clk_gated
);
  import refresh_ctl_pkg::*;

  localparam int TRFC_CYC = `CEIL_CYC(`TRFC_NS);
  localparam int TXS_CYC = `CEIL_CYC(`TXS_NS);

  typedef struct packed {
    logic [1:0][5:0] sync;
    logic [1:0][`COL_W-1:0] col_sync;
    dev_state_t st;
    logic [`ROW_W-1:0] row;
    logic [`CNT_W-1:0] self_cnt;
    logic ref_pulse;
    logic dll;
    logic dll_rst;
    logic bl8;
    logic [`COL_W-1:0] col;
    logic acc;
    logic gated;
  } dev_reg_t;
  dev_reg_t s;
  dev_reg_t next_s;
  logic [5:0] pins;
  logic [5:0] p;
  cmd_t cmd;
  logic wait_load;
  logic [`CNT_W-1:0] wait_value;
  logic wait_done;

  // Pin inputs cross from the controller through two flops.
  assign pins = {link.cs_n, link.ras_n, link.cas_n, link.we_n, link.cke,
                 link.a12};
  assign p = s.sync[1];

  // Command decode from synchronised pins.
  always_comb begin
    cmd = CMD_NOP;
    if (!p[5]) begin
      if (!p[4] && !p[3] && p[2]) begin
        cmd = p[1] ? CMD_REF : CMD_SRE;
      end else if (p[4] && !p[3] && p[2]) begin
        cmd = CMD_RD;
      end else if (p[4] && !p[3] && !p[2]) begin
        cmd = CMD_WR;
      end else if (!(p[4] && p[3] && p[2])) begin
        cmd = CMD_OTHER;
      end
    end
  end

  // Refresh and exit waits share one timer. Its load comes from
  // registered state only, so done never feeds back into load.
  assign wait_load = (s.st == DEV_IDLE && cmd == CMD_REF) ||
                     (s.st == DEV_SELF && p[1]);
  assign wait_value = (s.st == DEV_SELF) ? `CNT_W'(TXS_CYC)
                                         : `CNT_W'(TRFC_CYC);

  cycle_timer #(
    .W(`CNT_W)
  ) cycle_timer_i (
    .clk(clk),
    .rst(rst || !link.reset_n),
    .load(wait_load),
    .value(wait_value),
    .done(wait_done)
  );

  always_comb begin
    next_s = s;
    next_s.sync[0] = pins;
    next_s.sync[1] = s.sync[0];
    // The column travels with the command pins, so it sees the same
    // two flops and lines up with the decoded command.
    next_s.col_sync[0] = link.col;
    next_s.col_sync[1] = s.col_sync[0];
    next_s.ref_pulse = 1'b0;
    next_s.acc = 1'b0;
    next_s.dll_rst = 1'b0;
    case (s.st)
      DEV_IDLE: begin
        // Address pins play no part in refresh rows.
        if (cmd == CMD_REF) begin
          next_s.row = s.row + 1'b1;
          next_s.ref_pulse = 1'b1;
          next_s.st = DEV_REFRESH;
        end else if (cmd == CMD_SRE) begin
          next_s.st = DEV_SELF;
          next_s.dll = 1'b0;
          next_s.gated = 1'b1;
          next_s.self_cnt = '0;
          // First internal refresh fires on entry, inside tCKE.
          next_s.row = s.row + 1'b1;
          next_s.ref_pulse = 1'b1;
        end else if (cmd == CMD_RD || cmd == CMD_WR) begin
          // A12 picks the burst; it never reaches the column.
          next_s.bl8 = p[0];
          next_s.col = s.col_sync[1];
          next_s.acc = 1'b1;
        end
      end
      DEV_REFRESH: begin
        // Any command is ignored until the refresh cycle ends.
        if (wait_done) begin
          next_s.st = DEV_IDLE;
        end
      end
      DEV_SELF: begin
        // Only CKE and reset are watched here.
        if (s.self_cnt >= `CNT_W'(TREFI_CYC - 1)) begin
          next_s.self_cnt = '0;
          next_s.row = s.row + 1'b1;
          next_s.ref_pulse = 1'b1;
        end else begin
          next_s.self_cnt = s.self_cnt + 1'b1;
        end
        if (p[1]) begin
          next_s.st = DEV_EXIT;
          next_s.gated = 1'b0;
          next_s.dll = 1'b1;
          next_s.dll_rst = 1'b1;
        end
      end
      DEV_EXIT: begin
        // Internal refresh in progress completes during tXS.
        if (wait_done) begin
          next_s.st = DEV_IDLE;
        end
      end
      default: begin
        next_s.st = DEV_IDLE;
      end
    endcase
  end

  // Reset pin from the controller acts like the local reset.
  always_ff @(posedge clk) begin
    if (rst || !link.reset_n) begin
      s <= '0;
      s.sync <= {2{6'h3F}};
      s.dll <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Write strobe slips only affect stored data; no state here depends
  // on strobe timing, so the device keeps running.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= DEV_IDLE;
      refresh_row <= '0;
      refresh_pulse <= 1'b0;
      dll_on <= 1'b1;
      dll_reset <= 1'b0;
      burst_length_eight <= 1'b0;
      column <= '0;
      access_pulse <= 1'b0;
      clk_gated <= 1'b0;
    end else begin
      state <= s.st;
      refresh_row <= s.row;
      refresh_pulse <= s.ref_pulse;
      dll_on <= s.dll;
      dll_reset <= s.dll_rst;
      burst_length_eight <= s.bl8;
      column <= s.col;
      access_pulse <= s.acc;
      clk_gated <= s.gated;
    end
  end
endmodule : dram_refresh_device

// ==== hw/dram_refresh_controller.sv ====
// Controller end: refresh scheduling, self-refresh entry and exit.
`timescale 1ns/10ps
`include "refresh_ctl_defs.svh"
module dram_refresh_controller #(
  parameter int TREFI_CYC = `CEIL_CYC(`TREFI_NS),
  parameter int TXSDLL = `TXSDLL_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // User requests.
  input wire logic sr_req,
  input wire logic sr_exit,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_bl8,
  input wire logic [`COL_W-1:0] acc_col,
  // User status.
  output logic acc_done,
  output refresh_ctl_pkg::ctl_state_t state,
  output logic signed [4:0] debt,
  // Link.
  dram_cmd_if.controller link
);
  import refresh_ctl_pkg::*;

  localparam int TRFC_CYC = `CEIL_CYC(`TRFC_NS);
  localparam int TXS_CYC = `CEIL_CYC(`TXS_NS);
  localparam int TCKE_CYC = `CEIL_CYC(`TCKE_NS);
  localparam int TCKSRX_CYC = `CEIL_CYC(`TCKSRX_NS);

  typedef struct packed {
    ctl_state_t st;
    logic signed [4:0] debt;
    logic [`CNT_W-1:0] refi;
    logic [`CNT_W-1:0] wt;
    logic [3:0] pins;
    logic cke;
    logic a12;
    logic [`COL_W-1:0] col;
    logic clk_en;
    logic done;
  } ctl_reg_t;
  ctl_reg_t s;
  ctl_reg_t next_s;
  logic tick;

  assign tick = (s.refi == `CNT_W'(TREFI_CYC - 1));

  always_comb begin
    next_s = s;
    next_s.pins = 4'hF;
    next_s.done = 1'b0;
    next_s.refi = tick ? '0 : s.refi + 1'b1;
    if (s.wt != '0) begin
      next_s.wt = s.wt - 1'b1;
    end
    // Debt climbs per tREFI outside self-refresh, saturating at plus eight.
    if (tick && s.debt < 5'sd`DEBT_MAX && s.st != CTL_SELF) begin
      next_s.debt = s.debt + 5'sd1;
    end
    case (s.st)
      CTL_READY: begin
        if (s.wt == '0) begin
          if (s.debt >= 5'sd`DEBT_MAX || (sr_req && s.debt > 5'sd0)) begin
            // A tick on this edge is in next_s unless debt is already at eight, so it nets out.
            next_s.pins = 4'h1;
            next_s.debt = next_s.debt - 5'sd1;
            next_s.wt = `CNT_W'(TRFC_CYC);
            next_s.st = CTL_REF_WAIT;
          end else if (sr_req) begin
            // Banks idle and termination low are assumed here.
            next_s.pins = 4'h1;
            next_s.cke = 1'b0;
            // Self-refresh covers a refresh falling due on the entry edge.
            next_s.debt = s.debt;
            next_s.wt = `CNT_W'(TCKE_CYC);
            next_s.st = CTL_SELF;
          end else if (acc_req && !s.done && !acc_done) begin
            // A held request is not taken again while its answer shows.
            next_s.pins = acc_write ? 4'h4 : 4'h5;
            next_s.a12 = acc_bl8;
            next_s.col = acc_col;
            next_s.done = 1'b1;
            next_s.wt = acc_bl8 ? '0 : `CNT_W'(`TCCD_CYC - 1);
          end else if (s.debt > -5'sd`DEBT_MAX && tick) begin
            // Idle refresh on the tick; credit floor is minus eight.
            next_s.pins = 4'h1;
            next_s.debt = next_s.debt - 5'sd1;
            next_s.wt = `CNT_W'(TRFC_CYC);
            next_s.st = CTL_REF_WAIT;
          end
        end
      end
      CTL_REF_WAIT: begin
        if (s.wt == '0) begin
          next_s.st = CTL_READY;
        end
      end
      CTL_SELF: begin
        // CKE held low for tCKE at least; clock stops after tCKSRE.
        if (s.wt == '0) begin
          next_s.clk_en = 1'b0;
          if (sr_exit) begin
            next_s.clk_en = 1'b1;
            next_s.wt = `CNT_W'(TCKSRX_CYC);
            next_s.st = CTL_PREP;
          end
        end
      end
      CTL_PREP: begin
        if (s.wt == '0) begin
          next_s.cke = 1'b1;
          next_s.wt = `CNT_W'(TXSDLL);
          next_s.st = CTL_EXIT;
        end
      end
      CTL_EXIT: begin
        // NOPs through tXSDLL, which also covers tXS.
        if (s.wt == '0) begin
          next_s.st = CTL_READY;
        end
      end
      default: begin
        next_s.st = CTL_READY;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.pins <= 4'hF;
      s.cke <= 1'b1;
      s.clk_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      link.cs_n <= 1'b1;
      link.ras_n <= 1'b1;
      link.cas_n <= 1'b1;
      link.we_n <= 1'b1;
      link.cke <= 1'b1;
      link.a12 <= 1'b0;
      link.col <= '0;
      link.reset_n <= 1'b0;
      link.clk_en <= 1'b1;
      acc_done <= 1'b0;
      state <= CTL_READY;
      debt <= '0;
    end else begin
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= s.pins;
      link.cke <= s.cke;
      link.a12 <= s.a12;
      link.col <= s.col;
      link.reset_n <= 1'b1;
      link.clk_en <= s.clk_en;
      acc_done <= s.done;
      state <= s.st;
      debt <= s.debt;
    end
  end
endmodule : dram_refresh_controller

// ==== tb/dram_refresh_props.sv ====
// Checker for the command link between the controller and device ends.
`timescale 1ns/10ps
`include "refresh_ctl_defs.svh"
module dram_refresh_props #(
  parameter int TXSDLL = `TXSDLL_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Link.
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic a12,
  input wire logic [`COL_W-1:0] col,
  input wire logic reset_n,
  input wire logic clk_en
);
  // Last cycle of the exit window in which DLL commands stay forbidden.
  localparam int XSDLL_LAST = TXSDLL - 1;
  logic cmd;
  logic ref_cmd;
  logic sre_cmd;
  logic acc_cmd;
  logic rd_cmd;
  assign cmd = !cs_n && !(ras_n && cas_n && we_n);
  assign ref_cmd = cmd && !ras_n && !cas_n && we_n && cke;
  assign sre_cmd = cmd && !ras_n && !cas_n && we_n && !cke;
  assign acc_cmd = cmd && ras_n && !cas_n;
  assign rd_cmd = acc_cmd && we_n;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  //--------------------------------------------------------------------
  // Link timing
  //--------------------------------------------------------------------
  ref_gap_a: assert property (
    ref_cmd |=> !cmd [*6])
    else $error("command inside refresh cycle time");
  chop_space_a: assert property (
    acc_cmd && !a12 |=> !cmd [*3])
    else $error("chopped burst spacing too short");
  sre_hold_a: assert property (
    sre_cmd |=> !cke [*2])
    else $error("clock enable not held low after entry");
  clk_stop_a: assert property (
    $fell(clk_en) |-> !cke && !$past(cke) && !$past(cke, 2))
    else $error("link clock stopped too early");
  clk_stable_a: assert property (
    $rose(cke) |-> $past(clk_en) && $past(clk_en, 2))
    else $error("exit before link clock stable");
  exit_nop_a: assert property (
    $rose(cke) |-> !cmd [*7])
    else $error("command inside exit window");
  exit_dll_a: assert property (
    $rose(cke) |-> not (##[0:XSDLL_LAST] rd_cmd))
    else $error("read before DLL relock time");
  exit_cke_a: assert property (
    $rose(cke) |=> cke [*8])
    else $error("clock enable dropped during exit window");
endmodule : dram_refresh_props

// ==== tb/dram_refresh_selfrefresh_control_tb.sv ====
// Bench joining the controller and device ends across the command link.
`timescale 1ns/10ps
`include "refresh_ctl_defs.svh"
module dram_refresh_selfrefresh_control_tb;
  import refresh_ctl_pkg::*;
  // Short refresh interval and DLL wait keep the run brief.
  localparam int TREFI = 20;
  localparam int XSDLL = 16;
  typedef struct packed {
    logic wr;
    logic bl8;
    logic [`COL_W-1:0] col;
  } acc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sr_req = 1'b0;
  logic sr_exit = 1'b0;
  logic acc_req = 1'b0;
  logic acc_write = 1'b0;
  logic acc_bl8 = 1'b0;
  logic [`COL_W-1:0] acc_col = '0;
  logic acc_done;
  ctl_state_t ctl_state;
  logic signed [4:0] debt;
  dev_state_t dev_state;
  logic [`ROW_W-1:0] refresh_row;
  logic [`ROW_W-1:0] last_row;
  logic refresh_pulse;
  logic dll_on;
  logic dll_reset;
  logic burst_length_eight;
  logic [`COL_W-1:0] column;
  logic access_pulse;
  logic clk_gated;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  acc_row_t rows [4];
  dram_cmd_if link_if();
  dram_refresh_controller #(.TREFI_CYC(TREFI), .TXSDLL(XSDLL))
    dram_refresh_controller_i (.clk(clk), .rst(rst), .sr_req(sr_req),
    .sr_exit(sr_exit), .acc_req(acc_req), .acc_write(acc_write),
    .acc_bl8(acc_bl8), .acc_col(acc_col), .acc_done(acc_done),
    .state(ctl_state), .debt(debt), .link(link_if));
  dram_refresh_device #(.TREFI_CYC(TREFI)) dram_refresh_device_i (
    .clk(clk), .rst(rst), .link(link_if), .state(dev_state),
    .refresh_row(refresh_row), .refresh_pulse(refresh_pulse),
    .dll_on(dll_on), .dll_reset(dll_reset),
    .burst_length_eight(burst_length_eight), .column(column),
    .access_pulse(access_pulse), .clk_gated(clk_gated));
  dram_refresh_props #(.TXSDLL(XSDLL)) dram_refresh_props_i (
    .clk(clk), .rst(rst), .cs_n(link_if.cs_n), .ras_n(link_if.ras_n),
    .cas_n(link_if.cas_n), .we_n(link_if.we_n), .cke(link_if.cke),
    .a12(link_if.a12), .col(link_if.col), .reset_n(link_if.reset_n),
    .clk_en(link_if.clk_en));
  initial begin
    forever #20 clk = ~clk;
  end
  //--------------------------------------------------------------------
  // Shared tasks
  //--------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  function automatic logic sig(input int which);
    case (which)
      0: return acc_done;
      1: return access_pulse;
      2: return refresh_pulse;
      3: return dll_reset;
      4: return debt == 5'sd8;
      5: return dev_state == DEV_SELF;
      6: return ctl_state == CTL_READY;
      default: return !link_if.cs_n && !link_if.ras_n && !link_if.cke;
    endcase
  endfunction : sig
  // Bounded wait; running out of cycles shows up as a failed compare.
  // Values are read at the edge, as the design itself samples them.
  task automatic wait_sig(input int which, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sig(which) !== 1'b1 && n < lim);
    chk({15'h0000, sig(which)}, 16'h0001);
  endtask : wait_sig
  task automatic do_access(input acc_row_t r);
    @(posedge clk);
    acc_req <= 1'b1;
    acc_write <= r.wr;
    acc_bl8 <= r.bl8;
    acc_col <= r.col;
    wait_sig(0, 400);
    acc_req <= 1'b0;
    wait_sig(1, 10);
    chk({6'h00, column}, {6'h00, r.col});
    chk({15'h0000, burst_length_eight}, {15'h0000, r.bl8});
  endtask : do_access
  // Debt limits and the run ceiling are watched on every cycle.
  always @(posedge clk) begin
    cycles++;
    if (!rst) begin
      chk({15'h0000, debt <= 5'sd8 && debt >= -5'sd8}, 16'h0001);
    end
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  //--------------------------------------------------------------------
  // Main sequence
  //--------------------------------------------------------------------
  initial begin
    rows[0] = '{1'b0, 1'b0, 10'h3FF};
    rows[1] = '{1'b1, 1'b1, 10'h000};
    rows[2] = '{1'b1, 1'b0, 10'h155};
    rows[3] = '{1'b0, 1'b1, 10'h2AA};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (rows[i]) begin
      do_access(rows[i]);
    end
    wait_sig(2, 200);
    last_row = refresh_row;
    wait_sig(2, 200);
    chk({1'b0, refresh_row}, {1'b0, last_row + 15'h0001});
    // A steady stream of chopped accesses takes every refresh slot, so
    // the debt climbs to its ceiling and a refresh is forced in.
    @(posedge clk);
    acc_req <= 1'b1;
    acc_write <= 1'b1;
    acc_bl8 <= 1'b0;
    acc_col <= 10'h0F0;
    wait_sig(4, 300);
    wait_sig(2, 40);
    chk({11'h000, debt}, 16'h0007);
    acc_req <= 1'b0;
    sr_req <= 1'b1;
    wait_sig(7, 600);
    chk({15'h0000, debt <= 5'sd0}, 16'h0001);
    wait_sig(2, 6);
    wait_sig(5, 10);
    chk({15'h0000, dll_on}, 16'h0000);
    chk({15'h0000, clk_gated}, 16'h0001);
    wait_sig(2, TREFI + 2);
    sr_req <= 1'b0;
    sr_exit <= 1'b1;
    wait_sig(3, 60);
    wait_sig(6, 100);
    sr_exit <= 1'b0;
    chk({15'h0000, dll_on}, 16'h0001);
    chk({13'h0000, dev_state}, {13'h0000, DEV_IDLE});
    do_access(rows[0]);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({13'h0000, dev_state}, {13'h0000, DEV_IDLE});
    chk({13'h0000, ctl_state}, {13'h0000, CTL_READY});
    chk({11'h000, debt}, 16'h0000);
    chk({15'h0000, dll_on}, 16'h0001);
    do_access(rows[2]);
    print_verdict();
  end
endmodule : dram_refresh_selfrefresh_control_tb
